// >>> verilog/liu_channel_alarm_irq_and_error_insert.sv
`timescale 1ns/10ps
`include "liu_alarm_regs.svh"

// Summary of operation
// RULE1: rising trigger inverts exactly one pattern bit
// RULE2: trigger sampled on transmit clock rising edge
// RULE3: software writes zero before writing one
// RULE4: per-channel enable register, bits 7,3 unused
// RULE5: enable bits map six sources, one enables
// RULE6: interrupt needs source enable and global enable
// RULE7: status tracks conditions regardless of masking
// RULE8: bit 6 shows transmit driver failure
// RULE9: bit 5 shows fifo pointers within three
// RULE10: bit 4 shows line code violation by default
// RULE11: global select bit shows counter overflow instead
// RULE12: bit 2 shows all-ones alarm signal
// RULE13: code violation interrupt also needs global enable
// RULE14: bit 1 signal loss, bit 0 pattern
// RULE15: change bits latch, interrupt, clear on read
// RULE16: interrupt held while enabled change bits pending
// RULE17: all enables and status reset to zero
module liu_channel_alarm_irq_and_error_insert
  import liu_alarm_pkg::*;
#(
  parameter int CHANNELS = `CHANNEL_COUNT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port, one-cycle strobes
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // alarm detector levels
  input wire alarm_in_t [CHANNELS-1:0] alarm_in,
  // transmit pattern path
  input wire logic [CHANNELS-1:0] transmit_clock,
  input wire logic [CHANNELS-1:0] pattern_in,
  output logic [CHANNELS-1:0] pattern_out,
  // interrupt
  output logic irq
);

  logic rst_meta_reg, rst_n;
  alarm_in_t [CHANNELS-1:0] alarm_meta_reg, alarm_sync_reg;
  logic [CHANNELS-1:0] ctrl_reg, ctrl_next;
  alarm_byte_t [CHANNELS-1:0] ien_reg, ien_next;
  alarm_byte_t [CHANNELS-1:0] stat_reg, stat_next;
  alarm_byte_t [CHANNELS-1:0] chg_reg, chg_next;
  logic gie_reg, gie_next;
  logic sel_reg, sel_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // true when addr selects the given slot of channel ch
  function automatic logic slot_hit(logic [7:0] addr, int ch,
                                    logic [3:0] slot);
    slot_hit = (addr[7:4] == 4'(ch)) && (addr[3:0] == slot);
  endfunction

  // live status byte from detector levels
  function automatic alarm_byte_t status_of(alarm_in_t a, logic sel);
    alarm_byte_t s;
    s = alarm_byte_t'(`RESET_BYTE);
    s.driver_fail = a.driver_fail; // see RULE8
    s.fifo_limit = a.fifo_limit; // see RULE9
    s.code_violation = sel ? a.counter_overflow // see RULE11
                           : a.line_violation; // see RULE10
    s.all_ones = a.all_ones; // see RULE12
    s.signal_loss = a.signal_loss; // see RULE14
    s.pattern_detect = a.pattern_detect; // see RULE14
    return s;
  endfunction

  // control registers written over the register port
  always_comb begin
    ctrl_next = ctrl_reg;
    ien_next = ien_reg;
    gie_next = gie_reg;
    sel_next = sel_reg;
    if (reg_wr) begin
      if (reg_addr == `GLOBAL_IRQ_ADDR) begin
        gie_next = reg_wdata[`GLOBAL_IRQ_ENABLE_BIT]; // see RULE6
      end
      if (reg_addr == `GLOBAL_COUNT_SEL_ADDR) begin
        sel_next = reg_wdata[`GLOBAL_COUNT_SEL_BIT]; // see RULE11
      end
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (slot_hit(reg_addr, ch, `CHAN_SLOT_TEST_ERR)) begin
          ctrl_next[ch] = reg_wdata[`TEST_ERR_INSERT_BIT];
        end
        if (slot_hit(reg_addr, ch, `CHAN_SLOT_IRQ_EN)) begin
          ien_next[ch] = alarm_byte_t'(reg_wdata // see RULE4
                                       & `ALARM_USED_MASK);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '0; // see RULE17
      ien_reg <= '0; // see RULE17
      gie_reg <= 1'b0; // see RULE17
      sel_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      ien_reg <= ien_next;
      gie_reg <= gie_next;
      sel_reg <= sel_next;
    end
  end

  // live status and latched change bits of every channel
  always_comb begin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      // status follows detectors whatever the masks are
      stat_next[ch] = status_of(alarm_sync_reg[ch], sel_reg); // see RULE7
      chg_next[ch] = chg_reg[ch];
      if (reg_rd && slot_hit(reg_addr, ch, `CHAN_SLOT_CHANGE)) begin
        chg_next[ch] = alarm_byte_t'(`RESET_BYTE); // see RULE15
      end
      // a change in the read cycle survives the clear
      chg_next[ch] = alarm_byte_t'(chg_next[ch] // see RULE15
                     | (stat_next[ch] ^ stat_reg[ch]));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_meta_reg <= '0;
      alarm_sync_reg <= '0;
      stat_reg <= '0; // see RULE17
      chg_reg <= '0; // see RULE17
    end else begin
      alarm_meta_reg <= alarm_in;
      alarm_sync_reg <= alarm_meta_reg;
      stat_reg <= stat_next;
      chg_reg <= chg_next;
    end
  end

  // read data, loaded only by a read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = `RESET_BYTE;
      if (reg_addr == `GLOBAL_IRQ_ADDR) begin
        rdata_next[`GLOBAL_IRQ_ENABLE_BIT] = gie_reg;
      end
      if (reg_addr == `GLOBAL_COUNT_SEL_ADDR) begin
        rdata_next[`GLOBAL_COUNT_SEL_BIT] = sel_reg;
      end
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (slot_hit(reg_addr, ch, `CHAN_SLOT_TEST_ERR)) begin
          rdata_next[`TEST_ERR_INSERT_BIT] = ctrl_reg[ch];
        end
        if (slot_hit(reg_addr, ch, `CHAN_SLOT_IRQ_EN)) begin
          rdata_next = ien_reg[ch];
        end
        if (slot_hit(reg_addr, ch, `CHAN_SLOT_STATUS)) begin
          rdata_next = stat_reg[ch];
        end
        if (slot_hit(reg_addr, ch, `CHAN_SLOT_CHANGE)) begin
          rdata_next = chg_reg[ch]; // see RULE15
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // interrupt from latched changes under both masks
  always_comb begin
    logic pending;
    pending = 1'b0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      pending = pending | (|(chg_reg[ch] & ien_reg[ch])); // see RULE5
    end
    irq_next = gie_reg & pending; // see RULE6 see RULE13 see RULE16
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;

  // one inserter per channel on its own transmit clock
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ins
    bit_error_inserter u_ins (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .transmit_clock(transmit_clock[ch]),
      .pattern_in(pattern_in[ch]),
      .pattern_out(pattern_out[ch]),
      .bit_error_insert_trigger(ctrl_reg[ch]) // see RULE1
    );
  end

endmodule // liu_channel_alarm_irq_and_error_insert

// >>> include/liu_alarm_regs.svh
`ifndef LIU_ALARM_REGS_SVH
`define LIU_ALARM_REGS_SVH

// channel layout: channel n occupies 0x(n)0 .. 0x(n)F
`define CHANNEL_COUNT 8
`define CHAN_SLOT_TEST_ERR 4'h3
`define CHAN_SLOT_IRQ_EN 4'h4
`define CHAN_SLOT_STATUS 4'h5
`define CHAN_SLOT_CHANGE 4'h6

// bit-error insertion trigger position in the test error slot
`define TEST_ERR_INSERT_BIT 1

// alarm bit positions, shared by enable, status and change slots
`define ALARM_DRIVER_FAIL_BIT 6
`define ALARM_FIFO_LIMIT_BIT 5
`define ALARM_CODE_VIOL_BIT 4
`define ALARM_ALL_ONES_BIT 2
`define ALARM_SIGNAL_LOSS_BIT 1
`define ALARM_PATTERN_BIT 0
`define ALARM_USED_MASK 8'h77

// global registers
`define GLOBAL_IRQ_ADDR 8'hE0
`define GLOBAL_IRQ_ENABLE_BIT 0
`define GLOBAL_COUNT_SEL_ADDR 8'h81
`define GLOBAL_COUNT_SEL_BIT 7

// reset values
`define RESET_BYTE 8'h00

`endif

// >>> include/liu_alarm_pkg.sv
package liu_alarm_pkg;

  // raw detector levels of one channel
  typedef struct packed {
    logic driver_fail;
    logic fifo_limit;
    logic line_violation;
    logic counter_overflow;
    logic all_ones;
    logic signal_loss;
    logic pattern_detect;
  } alarm_in_t;

  // layout of the status, enable and change bytes
  typedef struct packed {
    logic unused7;
    logic driver_fail;
    logic fifo_limit;
    logic code_violation;
    logic unused3;
    logic all_ones;
    logic signal_loss;
    logic pattern_detect;
  } alarm_byte_t;

endpackage

// >>> verilog/bit_error_inserter.sv
`timescale 1ns/10ps
`include "liu_alarm_regs.svh"

module bit_error_inserter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // transmit side pins
  input wire logic transmit_clock,
  input wire logic pattern_in,
  output logic pattern_out,
  // control
  input wire logic bit_error_insert_trigger
);

  logic transmit_clock_meta_reg, transmit_clock_sync_reg, transmit_clock_prev_reg;
  logic pat_meta_reg, pat_sync_reg;
  logic trig_prev_reg, trig_prev_next;
  logic out_reg, out_next;
  logic transmit_clock_rise;

  // transmit clock rising edge seen in the system domain
  assign transmit_clock_rise = transmit_clock_sync_reg & ~transmit_clock_prev_reg; // see RULE2

  always_comb begin
    trig_prev_next = trig_prev_reg;
    out_next = out_reg;
    if (transmit_clock_rise) begin
      trig_prev_next = bit_error_insert_trigger; // see RULE2
      // one inverted bit per zero-to-one change
      if (bit_error_insert_trigger && !trig_prev_reg) begin
        out_next = ~pat_sync_reg; // see RULE1
      end else begin
        out_next = pat_sync_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_clock_meta_reg <= 1'b0;
      transmit_clock_sync_reg <= 1'b0;
      transmit_clock_prev_reg <= 1'b0;
      pat_meta_reg <= 1'b0;
      pat_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      transmit_clock_meta_reg <= transmit_clock;
      transmit_clock_sync_reg <= transmit_clock_meta_reg;
      transmit_clock_prev_reg <= transmit_clock_sync_reg;
      pat_meta_reg <= pattern_in;
      pat_sync_reg <= pat_meta_reg;
      trig_prev_reg <= trig_prev_next;
      out_reg <= out_next;
    end
  end

  assign pattern_out = out_reg;

endmodule // bit_error_inserter

// >>> verif/liu_alarm_chk.sv
`timescale 1ns/10ps
module liu_alarm_chk #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // transmit and interrupt
  input wire logic [CHANNELS-1:0] transmit_clock,
  input wire logic [CHANNELS-1:0] pattern_out,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic gie_reg;
  logic [2:0] acc_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gie_reg <= 1'b0;
      acc_reg <= 3'h0;
    end else begin
      acc_reg <= {acc_reg[1:0], reg_rd | reg_wr};
      if (reg_wr && reg_addr == 8'hE0)
        gie_reg <= reg_wdata[0];
    end
  end
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    reg_rd && !reg_addr[7]
    && !(reg_addr[3:0] inside {4'h3, 4'h4, 4'h5, 4'h6})
    |=> reg_rdata == 8'h00)
    else $error("unmapped slot read nonzero");
  a_alarm_reserved: assert property (
    reg_rd && !reg_addr[7] && reg_addr[3:0] inside {4'h4, 4'h5, 4'h6}
    |=> !reg_rdata[7] && !reg_rdata[3])
    else $error("unused alarm bit read as one");
  a_trigger_reserved: assert property (
    reg_rd && !reg_addr[7] && reg_addr[3:0] == 4'h3
    |=> (reg_rdata & 8'hFD) == 8'h00)
    else $error("unused trigger bit read as one");
  a_select_reserved: assert property (
    reg_rd && reg_addr == 8'h81 |=> reg_rdata[6:0] == 7'h00)
    else $error("unused select bit read as one");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> acc_reg != 3'h0)
    else $error("interrupt dropped without an access");
  a_gie_gates_irq: assert property (
    !gie_reg && !$past(gie_reg) |-> !irq)
    else $error("interrupt with global enable off");
  a_pattern_on_edge: assert property (
    ((pattern_out ^ $past(pattern_out))
    & ~($past(transmit_clock, 2) & ~$past(transmit_clock, 6))) == '0)
    else $error("pattern output moved off a transmit edge");
endmodule // liu_alarm_chk

bind liu_channel_alarm_irq_and_error_insert liu_alarm_chk #(
  .CHANNELS(CHANNELS)
) chk_inst (
  .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .transmit_clock, .pattern_out, .irq
);

// >>> verif/liu_channel_alarm_irq_and_error_insert_tb.sv
`timescale 1ns/10ps
module liu_channel_alarm_irq_and_error_insert_tb
  import liu_alarm_pkg::*;
;
  logic sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  logic irq, g, s1 = 0, s2 = 0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, en, s;
  logic [7:0] transmit_clock = '0, pattern_in = '0, pattern_out;
  logic [3:0] c;
  alarm_in_t [7:0] alarm_in = '0;
  alarm_in_t a;
  logic [7:0] q[$];
  int n_mismatch = 0, comparisons = 0, seed = 29;

  liu_channel_alarm_irq_and_error_insert
    liu_channel_alarm_irq_and_error_insert_inst (
    .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .alarm_in, .transmit_clock, .pattern_in, .pattern_out,
    .irq
  );

  initial forever #5 sys_clk = ~sys_clk;

  function automatic logic [7:0] stat(alarm_in_t x, logic sel);
    return {1'b0, x.driver_fail, x.fifo_limit,
      sel ? x.counter_overflow : x.line_violation, 1'b0, x.all_ones,
      x.signal_loss, x.pattern_detect};
  endfunction

  task automatic check(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one register access; reads note the expected byte
  task automatic acc(logic w, logic [7:0] ad, logic [7:0] d);
    if (!w) q.push_back(d);
    @(posedge sys_clk) #1;
    reg_addr = ad;
    reg_wdata = d;
    {reg_wr, reg_rd} = {w, !w};
    @(posedge sys_clk) #1;
    {reg_wr, reg_rd} = 2'b00;
  endtask

  // one transmit clock period on channel c
  task automatic txb(logic b, logic e);
    pattern_in[c] = b;
    transmit_clock[c] = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 transmit_clock[c] = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 check(8'(pattern_out[c]), 8'(b ^ e));
  endtask

  always @(negedge sys_clk) begin
    if (s2) check(reg_rdata, q.pop_front());
    s2 = s1;
    s1 = reg_rd;
  end

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    #1 arst_n = 1;
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 32; k++)
      acc(0, {1'b0, 3'(k / 4), 4'(3 + k % 4)}, 8'h00);
    acc(0, 8'hE0, 8'h00);
    acc(0, 8'h07, 8'h00);
    acc(1, 8'h25, 8'hFF);
    acc(0, 8'h25, 8'h00);
    for (int i = 0; i < 14; i++) begin
      c = 4'($random(seed) & 7);
      en = 8'($random(seed));
      g = 1'($random(seed));
      a = alarm_in_t'(7'h40 >> (i % 7));
      s = stat(a, i > 6);
      acc(1, 8'h81, {i > 6, 7'h00});
      acc(1, 8'hE0, {7'h00, g});
      acc(1, {c, 4'h4}, en);
      acc(0, 8'h81, {i > 6, 7'h00});
      acc(0, 8'hE0, {7'h00, g});
      acc(0, {c, 4'h4}, en & 8'h77);
      acc(0, {c, 4'h6}, 8'h00);
      alarm_in[c] = a;
      repeat (6) @(posedge sys_clk);
      #1 check(8'(irq), 8'(g && (s & en) != 8'h00));
      acc(0, {c, 4'h5}, s);
      acc(0, {c, 4'h6}, s);
      repeat (4) @(posedge sys_clk);
      #1 check(8'(irq), 8'h00);
      alarm_in[c] = '0;
      repeat (6) @(posedge sys_clk);
      acc(0, {c, 4'h6}, s);
      acc(0, {c, 4'h5}, 8'h00);
    end
    c = 4'($random(seed) & 7);
    acc(1, {c, 4'h3}, 8'h00);
    txb(1'($random(seed)), 1'b0);
    acc(1, {c, 4'h3}, 8'h02);
    acc(0, {c, 4'h3}, 8'h02);
    txb(1'($random(seed)), 1'b1);
    txb(1'($random(seed)), 1'b0);
    acc(1, {c, 4'h3}, 8'h00);
    txb(1'($random(seed)), 1'b0);
    acc(1, {c, 4'h3}, 8'h02);
    txb(1'($random(seed)), 1'b1);
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule // liu_channel_alarm_irq_and_error_insert_tb
